/* File: hdl/block_ram_pkg.sv */
// Purpose: constants, types and helpers for the configurable block ram tile
// Assumes: one 100 MHz clock, registers reached over AXI4-Lite
// Notes: rules of the tile follow
// Function
// - 16Kx1 to 512x36; true dual port stops at x18
// - each port picks its own width
// - bits stored linearly, word zero lsb first
// - same linear order for every port width
// - contents preloadable before ports start operating
// - preloaded and write-locked tile acts as rom
// - address and data captured on rising edge
// - read data only after the capturing edge
// - 18 kbit, registered ports, per-port clock enable
// - ninth bit parity; byte enables at x18, x36
package block_ram_pkg;
    localparam int unsigned DATA_W = 36;
    localparam int unsigned ADDR_W = 14;
    localparam int unsigned BE_W = 4;
    localparam int unsigned LANE_W = 9;
    localparam int unsigned IDX_W = 15;
    localparam int unsigned MEM_BITS = 32'h0000_4800; // 18 kbit including parity bits
    localparam int unsigned AXI_ADDR_W = 8;
    // width codes
    localparam logic [2:0] WID_1 = 3'h0;
    localparam logic [2:0] WID_2 = 3'h1;
    localparam logic [2:0] WID_4 = 3'h2;
    localparam logic [2:0] WID_9 = 3'h3;
    localparam logic [2:0] WID_18 = 3'h4;
    localparam logic [2:0] WID_36 = 3'h5;
    // memory modes
    localparam logic [1:0] MODE_SP = 2'h0;
    localparam logic [1:0] MODE_TDP = 2'h1;
    localparam logic [1:0] MODE_PDP = 2'h2;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_CFG = 8'h04;
    localparam logic [7:0] OFF_INIT_ADDR = 8'h08;
    localparam logic [7:0] OFF_INIT_LO = 8'h0C;
    localparam logic [7:0] OFF_INIT_HI = 8'h10;
    localparam logic [7:0] OFF_STATUS = 8'h14;
    // field positions
    localparam int unsigned CTRL_RUN = 0;
    localparam int unsigned CTRL_LOCK = 1;
    localparam int unsigned CTRL_PARGEN = 2;
    localparam int unsigned CFG_MODE_LSB = 0;
    localparam int unsigned CFG_WA_LSB = 4;
    localparam int unsigned CFG_WB_LSB = 8;
    localparam int unsigned STAT_RUN = 0;
    localparam int unsigned STAT_COLL = 1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic ce;
        logic we;
        logic [BE_W-1:0] be;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } port_req_type;

    typedef struct packed {
        logic [1:0] mode;
        logic [2:0] width_a;
        logic [2:0] width_b;
    } cfg_type;

    function automatic logic [5:0] width_of(input logic [2:0] code);
        case (code)
            WID_2: width_of = 6'h02;
            WID_4: width_of = 6'h04;
            WID_9: width_of = 6'h09;
            WID_18: width_of = 6'h12;
            WID_36: width_of = 6'h24;
            default: width_of = 6'h01;
        endcase
    endfunction : width_of

    // address bits used per width, log2 of the depth
    function automatic logic [3:0] abits_of(input logic [2:0] code);
        case (code)
            WID_2: abits_of = 4'hD;
            WID_4: abits_of = 4'hC;
            WID_9: abits_of = 4'hB;
            WID_18: abits_of = 4'hA;
            WID_36: abits_of = 4'h9;
            default: abits_of = 4'hE;
        endcase
    endfunction : abits_of

    // linear bit index of word zero lsb of the addressed word
    function automatic logic [IDX_W-1:0] base_of(input logic [2:0] code,
                                                  input logic [ADDR_W-1:0] addr);
        logic [ADDR_W-1:0] mask;
        logic [19:0] prod;
        mask = ADDR_W'((32'h0000_0001 << abits_of(code)) - 32'h0000_0001);
        prod = 20'(addr & mask) * 20'(width_of(code));
        return prod[IDX_W-1:0];
    endfunction : base_of

    // unknown codes fall back to x1; x36 is folded to x18 in true dual port
    function automatic logic [2:0] fix_width(input logic [1:0] mode, input logic [2:0] code);
        if (code > WID_36) return WID_1;
        if (mode == MODE_TDP && code == WID_36) return WID_18;
        return code;
    endfunction : fix_width
endpackage : block_ram_pkg

/* File: hdl/configurable_block_ram.sv */
// Purpose: 18 kbit block ram tile with mixed-width ports and axi4-lite setup
// Assumes: user ports are on ref_clk_i; clock enables gate each port
// Notes: memory has no reset; preload it while run is low
//
// The register offsets and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/100ps
module configurable_block_ram
    import block_ram_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    // user ports
    input wire port_req_type port_a_i,
    input wire port_req_type port_b_i,
    output logic [DATA_W-1:0] rdata_a_o,
    output logic [DATA_W-1:0] rdata_b_o,
    // axi4-lite write channels
    input wire logic [AXI_ADDR_W-1:0] awaddr_i,
    input wire logic awvalid_i,
    output logic awready_o,
    input wire logic [31:0] wdata_i,
    input wire logic [3:0] wstrb_i,
    input wire logic wvalid_i,
    output logic wready_o,
    output logic [1:0] bresp_o,
    output logic bvalid_o,
    input wire logic bready_i,
    // axi4-lite read channels
    input wire logic [AXI_ADDR_W-1:0] araddr_i,
    input wire logic arvalid_i,
    output logic arready_o,
    output logic [31:0] rdata_o,
    output logic [1:0] rresp_o,
    output logic rvalid_o,
    input wire logic rready_i
);

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);

    logic mem_q [0:MEM_BITS-1];
    logic run_q, lock_q, pargen_q, coll_q;
    cfg_type cfg_q;
    logic [ADDR_W-1:0] init_addr_q;
    logic [3:0] init_hi_q;
    logic aw_held_q, w_held_q;
    logic [AXI_ADDR_W-1:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic wr_fire, init_wr, ar_fire;
    logic wr_a_en, rd_a_en, wr_b_en, rd_b_en, collide;
    logic [IDX_W-1:0] base_a, base_b, base_i;
    logic [5:0] wid_a, wid_b;
    logic [DATA_W-1:0] wd_a, wd_b, wd_i;
    logic [31:0] rd_mux;
    logic rd_hit;

    // port roles per mode: pseudo dual port writes on a and reads on b
    assign wr_a_en = run_q & ~lock_q & port_a_i.ce & port_a_i.we;
    assign rd_a_en = run_q & port_a_i.ce & ~port_a_i.we & (cfg_q.mode != MODE_PDP);
    assign wr_b_en = run_q & ~lock_q & port_b_i.ce & port_b_i.we & (cfg_q.mode == MODE_TDP);
    assign rd_b_en = run_q & port_b_i.ce & ~port_b_i.we & (cfg_q.mode != MODE_SP);

    // every port maps its word onto one linear bit space
    assign wid_a = width_of(cfg_q.width_a);
    assign wid_b = width_of(cfg_q.width_b);
    assign base_a = base_of(cfg_q.width_a, port_a_i.addr);
    assign base_b = base_of(cfg_q.width_b, port_b_i.addr);
    assign base_i = base_of(cfg_q.width_a, init_addr_q);

    // optional parity fill of the ninth bit of each byte lane
    always_comb begin
        wd_a = port_a_i.wdata;
        wd_b = port_b_i.wdata;
        wd_i = {init_hi_q, w_data_q};
        if (pargen_q) begin
            for (int l = 0; l < BE_W; l++) begin
                wd_a[l*LANE_W+8] = ^port_a_i.wdata[l*LANE_W +: 8];
                wd_b[l*LANE_W+8] = ^port_b_i.wdata[l*LANE_W +: 8];
                wd_i[l*LANE_W+8] = ^wd_i[l*LANE_W +: 8];
            end
        end
    end

    // overlapping bit ranges with a writer involved is flagged, not resolved
    assign collide = (wr_a_en | wr_b_en) & (wr_a_en | rd_a_en) & (wr_b_en | rd_b_en)
                   & (20'(base_a) < 20'(base_b) + 20'(wid_b))
                   & (20'(base_b) < 20'(base_a) + 20'(wid_a));

    // storage: a writes first, then b, init last; init only runs while ports are idle
    always_ff @(posedge ref_clk_i) begin
        for (int i = 0; i < DATA_W; i++) begin
            if (wr_a_en && i < wid_a && (cfg_q.width_a < WID_18 || port_a_i.be[i/LANE_W])) begin
                mem_q[IDX_W'(base_a + IDX_W'(i))] <= wd_a[i];
            end
            if (wr_b_en && i < wid_b && (cfg_q.width_b < WID_18 || port_b_i.be[i/LANE_W])) begin
                mem_q[IDX_W'(base_b + IDX_W'(i))] <= wd_b[i];
            end
            if (init_wr && i < wid_a) begin
                mem_q[IDX_W'(base_i + IDX_W'(i))] <= wd_i[i];
            end
        end
    end

    // registered read ports; bits above the port width read zero
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_a_o <= '0;
            rdata_b_o <= '0;
        end else begin
            if (rd_a_en) begin
                for (int i = 0; i < DATA_W; i++) begin
                    rdata_a_o[i] <= (i < wid_a) ? mem_q[IDX_W'(base_a + IDX_W'(i))] : 1'b0;
                end
            end
            if (rd_b_en) begin
                for (int i = 0; i < DATA_W; i++) begin
                    rdata_b_o[i] <= (i < wid_b) ? mem_q[IDX_W'(base_b + IDX_W'(i))] : 1'b0;
                end
            end
        end
    end

    // axi write side: address and data may arrive in either order
    assign awready_o = ~aw_held_q;
    assign wready_o = ~w_held_q;
    assign wr_fire = aw_held_q & w_held_q & ~bvalid_o;
    // preload obeys the same byte-zero strobe as the ctrl, cfg and init register writes; the status clear ignores it
    assign init_wr = wr_fire & w_strb_q[0] & (aw_addr_q == OFF_INIT_LO) & ~run_q;

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            aw_addr_q <= '0;
            w_data_q <= '0;
            w_strb_q <= '0;
            bvalid_o <= 1'b0;
            bresp_o <= RESP_OKAY;
        end else begin
            if (awvalid_i && !aw_held_q) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= awaddr_i;
            end
            if (wvalid_i && !w_held_q) begin
                w_held_q <= 1'b1;
                w_data_q <= wdata_i;
                w_strb_q <= wstrb_i;
            end
            if (wr_fire) begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                bvalid_o <= 1'b1;
                bresp_o <= (aw_addr_q > OFF_STATUS || aw_addr_q[1:0] != 2'h0) ? RESP_SLVERR
                                                                               : RESP_OKAY;
            end else if (bready_i) begin
                bvalid_o <= 1'b0;
            end
        end
    end

    // control registers; configuration is frozen while the ports run
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            run_q <= 1'b0;
            lock_q <= 1'b0;
            pargen_q <= 1'b0;
            cfg_q <= '{mode: MODE_SP, width_a: WID_1, width_b: WID_1};
            init_addr_q <= '0;
            init_hi_q <= '0;
        end else if (wr_fire && w_strb_q[0]) begin
            case (aw_addr_q)
                OFF_CTRL: begin
                    run_q <= w_data_q[CTRL_RUN];
                    lock_q <= w_data_q[CTRL_LOCK];
                    pargen_q <= w_data_q[CTRL_PARGEN];
                end
                OFF_CFG: begin
                    if (!run_q) begin
                        cfg_q.mode <= w_data_q[CFG_MODE_LSB +: 2];
                        cfg_q.width_a <= fix_width(w_data_q[CFG_MODE_LSB +: 2],
                                                   w_data_q[CFG_WA_LSB +: 3]);
                        cfg_q.width_b <= fix_width(w_data_q[CFG_MODE_LSB +: 2],
                                                   w_data_q[CFG_WB_LSB +: 3]);
                    end
                end
                OFF_INIT_ADDR: init_addr_q <= w_data_q[ADDR_W-1:0];
                OFF_INIT_HI: init_hi_q <= w_data_q[3:0];
                OFF_INIT_LO: begin
                    if (!run_q) begin
                        init_addr_q <= init_addr_q + 14'h0001;
                    end
                end
                default: ;
            endcase
        end
    end

    // sticky collision flag: a new collision wins over a clear
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            coll_q <= 1'b0;
        end else if (collide) begin
            coll_q <= 1'b1;
        end else if (wr_fire && aw_addr_q == OFF_STATUS && w_data_q[STAT_COLL]) begin
            coll_q <= 1'b0;
        end
    end

    // read decode
    always_comb begin
        rd_mux = '0;
        rd_hit = 1'b1;
        case (araddr_i)
            OFF_CTRL: begin
                rd_mux[CTRL_RUN] = run_q;
                rd_mux[CTRL_LOCK] = lock_q;
                rd_mux[CTRL_PARGEN] = pargen_q;
            end
            OFF_CFG: begin
                rd_mux[CFG_MODE_LSB +: 2] = cfg_q.mode;
                rd_mux[CFG_WA_LSB +: 3] = cfg_q.width_a;
                rd_mux[CFG_WB_LSB +: 3] = cfg_q.width_b;
            end
            OFF_INIT_ADDR: rd_mux[ADDR_W-1:0] = init_addr_q;
            OFF_INIT_LO: rd_mux = '0;
            OFF_INIT_HI: rd_mux[3:0] = init_hi_q;
            OFF_STATUS: begin
                rd_mux[STAT_RUN] = run_q;
                rd_mux[STAT_COLL] = coll_q;
            end
            default: rd_hit = 1'b0;
        endcase
    end

    assign arready_o = ~rvalid_o;
    assign ar_fire = arvalid_i & ~rvalid_o;

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rvalid_o <= 1'b0;
            rdata_o <= '0;
            rresp_o <= RESP_OKAY;
        end else if (ar_fire) begin
            rvalid_o <= 1'b1;
            rdata_o <= rd_mux;
            rresp_o <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rready_i) begin
            rvalid_o <= 1'b0;
        end
    end

    // checks
    a_read_after_edge: assert property ($changed(rdata_a_o) |-> $past(rd_a_en))
        else $error("port a data changed without a captured read");
    a_tdp_no_x36: assert property (cfg_q.mode == MODE_TDP |->
        cfg_q.width_a != WID_36 && cfg_q.width_b != WID_36)
        else $error("true dual port holds a x36 width");
    a_lock_blocks_wr: assert property (lock_q |-> !wr_a_en && !wr_b_en)
        else $error("write accepted while locked");
    a_pdp_b_only_read: assert property (cfg_q.mode == MODE_PDP && port_a_i.ce |=>
        $stable(rdata_a_o))
        else $error("port a read in pseudo dual port mode");
    a_init_when_idle: assert property (init_wr |-> !run_q ##1
        init_addr_q == $past(init_addr_q) + 14'h0001)
        else $error("preload while running or address not advanced");
    a_collision_flag: assert property (collide |=> coll_q [*2] or (coll_q ##1 !coll_q))
        else $error("collision not recorded");
    a_narrow_zeros: assert property (rd_a_en && cfg_q.width_a == WID_1 |=>
        rdata_a_o[DATA_W-1:1] == '0)
        else $error("upper read bits not zero at x1");
    a_write_answer: assert property (wr_fire |=> bvalid_o && !aw_held_q && !w_held_q)
        else $error("write response missing");
    a_read_answer: assert property (ar_fire |=> rvalid_o ##0 !arready_o)
        else $error("read response missing");

endmodule : configurable_block_ram

/* File: test/fabric_user.sv */
// Purpose: fabric-side user logic in front of both tile ports
// Assumes: bench requests change just after a clock edge
// Notes: combinational, so no added latency; b is held back when either port writes the address the other uses
`timescale 1ns/100ps
module fabric_user
    import block_ram_pkg::*;
(
    // requests from the bench
    input wire port_req_type want_a_i,
    input wire port_req_type want_b_i,
    // requests towards the tile
    output port_req_type port_a_o,
    output port_req_type port_b_o
);
    // an unselected port floats: inverted lines, never the old value
    function automatic port_req_type settle(input port_req_type r);
        settle = r;
        if (!r.ce) begin
            settle.we = 1'b0;
            settle.addr = ~r.addr;
            settle.wdata = ~r.wdata;
        end
    endfunction : settle

    // a write meeting the other port on one word is undefined: hold b back
    always_comb begin
        port_a_o = settle(want_a_i);
        port_b_o = settle(want_b_i);
        if (want_a_i.ce && want_b_i.ce && want_a_i.addr == want_b_i.addr
            && (want_a_i.we || want_b_i.we)) begin
            port_b_o.ce = 1'b0;
        end
    end
endmodule : fabric_user

/* File: test/configurable_block_ram_tb.sv */
// Purpose: self-checking bench for the configurable block ram tile
// Assumes: one 100 MHz clock; user ports reached through fabric_user
// Notes: rows cover mixed-width mapping; hand tests cover rom, tdp, axi
`timescale 1ns/100ps
module configurable_block_ram_tb
    import block_ram_pkg::*;
;
    typedef struct packed {
        logic [2:0] wa;
        logic [2:0] wb;
        logic [13:0] aa;
        logic [35:0] ad;
        logic [13:0] ba;
        logic [35:0] exp;
    } row_type;
    localparam port_req_type IDLE = '0;
    logic clk, rstn;
    port_req_type want_a, want_b, port_a, port_b;
    logic [DATA_W-1:0] rd_a, rd_b;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    int num_errors, tests_run, i;
    // write a, read b, both mapped onto one linear bit array
    row_type rows[5] = '{
        '{WID_36, WID_1, 14'h0001, 36'h0_0000_0001, 14'h0024, 36'h0_0000_0001},
        '{WID_18, WID_9, 14'h0002, 36'h0_0002_A5C3, 14'h0005, 36'h0_0000_0152},
        '{WID_4, WID_2, 14'h0007, 36'h0_0000_000B, 14'h000F, 36'h0_0000_0002},
        '{WID_36, WID_18, 14'h0005, 36'h9_8765_4321, 14'h000B, 36'h0_0002_61D9},
        '{WID_1, WID_1, 14'h3FFF, 36'h0_0000_0001, 14'h3FFF, 36'h0_0000_0001}};

    fabric_user user (.want_a_i(want_a), .want_b_i(want_b), .port_a_o(port_a),
        .port_b_o(port_b));
    configurable_block_ram DUT (.ref_clk_i(clk), .rstn_i(rstn), .port_a_i(port_a),
        .port_b_i(port_b), .rdata_a_o(rd_a), .rdata_b_o(rd_b), .awaddr_i(awaddr),
        .awvalid_i(awvalid), .awready_o(awready), .wdata_i(wdata), .wstrb_i(wstrb),
        .wvalid_i(wvalid), .wready_o(wready), .bresp_o(bresp), .bvalid_o(bvalid),
        .bready_i(bready), .araddr_i(araddr), .arvalid_i(arvalid), .arready_o(arready),
        .rdata_o(rdata), .rresp_o(rresp), .rvalid_o(rvalid), .rready_i(rready));

    task complete_run;
        if (num_errors == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run

    task check(input string what, input logic [35:0] exp, input logic [35:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // flops update after the bench reads, so each edge shows pre-edge values
    task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        if (n == 50) begin
            num_errors++;
            complete_run();
        end else begin
            check("bresp", 36'(er), 36'(bresp));
        end
    endtask : axi_wr

    task axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        if (n == 50) begin
            num_errors++;
            complete_run();
        end else begin
            check("rresp", 36'(er), 36'(rresp));
            check("rdata", 36'(d), 36'(rdata));
        end
    endtask : axi_rd

    // one request per port for one cycle, then idle; read data lands after it
    task port_op(input port_req_type a, input port_req_type b);
        @(posedge clk);
        want_a <= a;
        want_b <= b;
        @(posedge clk);
        want_a <= IDLE;
        want_b <= IDLE;
        #1;
    endtask : port_op

    function automatic port_req_type req(logic we, logic [3:0] be, logic [13:0] a,
                                         logic [35:0] d);
        return {1'b1, we, be, a, d};
    endfunction : req

    function automatic logic [31:0] cfgw(logic [1:0] m, logic [2:0] wa, logic [2:0] wb);
        return 32'({wb, 1'b0, wa, 2'b00, m});
    endfunction : cfgw

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // hang guard well above the length of the run
    initial begin
        #500000;
        num_errors++;
        complete_run();
    end

    initial begin
        {rstn, awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
        wstrb = 4'hF;
        want_a = IDLE;
        want_b = IDLE;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        check("rdata_a reset", 36'h0_0000_0000, rd_a);
        for (i = 0; i < 24; i += 4) axi_rd(8'(i), 32'h0000_0000, RESP_OKAY);
        // mixed widths in pseudo dual port
        foreach (rows[k]) begin
            axi_wr(OFF_CTRL, 32'h0000_0000, RESP_OKAY);
            axi_wr(OFF_CFG, cfgw(MODE_PDP, rows[k].wa, rows[k].wb), RESP_OKAY);
            axi_wr(OFF_CTRL, 32'h0000_0001, RESP_OKAY);
            port_op(req(1'b1, 4'hF, rows[k].aa, rows[k].ad), IDLE);
            port_op(IDLE, req(1'b0, 4'hF, rows[k].ba, 36'h0_0000_0000));
            check("row rdata_b", rows[k].exp, rd_b);
        end
        // preload then lock: writes refused, preload read back
        axi_wr(OFF_CTRL, 32'h0000_0000, RESP_OKAY);
        axi_wr(OFF_CFG, cfgw(MODE_SP, WID_36, WID_1), RESP_OKAY);
        axi_wr(OFF_INIT_ADDR, 32'h0000_0004, RESP_OKAY);
        axi_wr(OFF_INIT_HI, 32'h0000_000A, RESP_OKAY);
        axi_wr(OFF_INIT_LO, 32'h1234_5678, RESP_OKAY);
        axi_rd(OFF_INIT_ADDR, 32'h0000_0005, RESP_OKAY);
        axi_wr(OFF_CTRL, 32'h0000_0003, RESP_OKAY);
        port_op(req(1'b1, 4'hF, 14'h0004, 36'h0_0000_0000), IDLE);
        port_op(req(1'b0, 4'hF, 14'h0004, 36'h0_0000_0000), IDLE);
        check("rom rdata_a", 36'hA_1234_5678, rd_a);
        @(posedge clk);
        #1;
        check("rdata_a hold", 36'hA_1234_5678, rd_a);
        // true dual port folds x36 to x18; byte enables per lane
        axi_wr(OFF_CTRL, 32'h0000_0000, RESP_OKAY);
        axi_wr(OFF_CFG, cfgw(MODE_TDP, WID_36, WID_18), RESP_OKAY);
        axi_wr(OFF_CTRL, 32'h0000_0001, RESP_OKAY);
        port_op(req(1'b1, 4'hF, 14'h0001, 36'hF_FFFF_FFFF), IDLE);
        port_op(req(1'b1, 4'h2, 14'h0001, 36'h0_0000_0000), IDLE);
        port_op(req(1'b0, 4'hF, 14'h0001, 36'h0), req(1'b0, 4'hF, 14'h0001, 36'h0));
        check("tdp rdata_a", 36'h0_0000_01FF, rd_a);
        check("tdp rdata_b", 36'h0_0000_01FF, rd_b);
        // parity fill, then a cross-width overlap that only the sticky flag records
        axi_wr(OFF_CTRL, 32'h0000_0000, RESP_OKAY);
        axi_wr(OFF_CFG, cfgw(MODE_TDP, WID_18, WID_9), RESP_OKAY);
        axi_wr(OFF_CTRL, 32'h0000_0005, RESP_OKAY);
        port_op(req(1'b1, 4'hF, 14'h0002, 36'h0_0000_0001), IDLE);
        port_op(req(1'b0, 4'hF, 14'h0002, 36'h0), req(1'b0, 4'hF, 14'h0004, 36'h0));
        check("parity rdata_a", 36'h0_0000_0101, rd_a);
        check("parity rdata_b", 36'h0_0000_0101, rd_b);
        port_op(req(1'b1, 4'hF, 14'h0000, 36'h0), req(1'b0, 4'hF, 14'h0001, 36'h0));
        axi_rd(OFF_STATUS, 32'h0000_0003, RESP_OKAY);
        axi_wr(OFF_STATUS, 32'h0000_0002, RESP_OKAY);
        // unmapped and unaligned register accesses
        axi_rd(8'h18, 32'h0000_0000, RESP_SLVERR);
        axi_wr(8'h20, 32'h0000_0001, RESP_SLVERR);
        axi_wr(8'h05, 32'h0000_0000, RESP_SLVERR);
        axi_rd(OFF_STATUS, 32'h0000_0001, RESP_OKAY);
        // reset in mid-run: read ports and configuration fall back
        rstn <= 1'b0;
        @(posedge clk);
        rstn <= 1'b1;
        #1;
        check("rdata_a mid reset", 36'h0_0000_0000, rd_a);
        check("rdata_b mid reset", 36'h0_0000_0000, rd_b);
        axi_rd(OFF_CTRL, 32'h0000_0000, RESP_OKAY);
        axi_rd(OFF_CFG, 32'h0000_0000, RESP_OKAY);
        complete_run();
    end
endmodule : configurable_block_ram_tb
